// file: logic/bwc_bootstore.v
// Purpose: storage cell of the boot configuration byte
// Assumes: the cell is loaded with its shipped value under rstn
// Notes: read data always leave through a register, one cycle behind except on a write, which shows at once

// ============================================================
// boot byte cell
module bwc_bootstore #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] INIT = 8'h10
) (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire wr_en,
	input wire [WIDTH-1:0] wr_data,
	output reg [WIDTH-1:0] rd_data
);

	reg [WIDTH-1:0] cell_reg;

	// write port and registered read port, both frozen while ce is low
	always @(posedge clk) begin
		if (!rstn) begin
			cell_reg <= INIT;
			rd_data <= INIT;
		end else if (ce) begin
			if (wr_en)
				cell_reg <= wr_data;
			rd_data <= wr_en ? wr_data : cell_reg; // new value visible at once
		end
	end

endmodule

// file: logic/bwc_map.vh
// Purpose: constants of the burst wrap configuration register pair
// Assumes: single-bit serial command interface, 24-bit register address
// Notes: bit positions refer to both the boot and the live byte
`ifndef BWC_MAP_VH
`define BWC_MAP_VH

// ============================================================
// command codes
`define BWC_CMD_RD_ANY 8'h65
`define BWC_CMD_WR_ANY 8'h71
`define BWC_CMD_SET_BURST 8'hc0
`define BWC_CMD_RD_SLOW 8'h03
`define BWC_CMD_RD_FAST 8'h0b
`define BWC_CMD_RD_QUAD_IO 8'heb
`define BWC_CMD_RD_DDR_QUAD_IO 8'hed
`define BWC_CMD_RST_ENABLE 8'h66
`define BWC_CMD_RST 8'h99

// ============================================================
// register addresses carried by the generic register commands
`define BWC_ADDR_BOOT 24'h000004
`define BWC_ADDR_LIVE 24'h800004

// ============================================================
// field layout
`define BWC_DRIVE_HI 7
`define BWC_DRIVE_LO 5
`define BWC_WRAP_EN_N 4
`define BWC_WLEN_HI 1
`define BWC_WLEN_LO 0
`define BWC_WRITE_MASK 8'hf3
`define BWC_BOOT_DEFAULT 8'h10
`define BWC_DRIVE_DUP 3'h0
`define BWC_DRIVE_NOMINAL 3'h3

// ============================================================
// address and byte counts
`define BWC_ADDR_BYTES 2'h3
`define BWC_WIN_MIN 6'h07

`endif

// file: logic/bwc_top.v
// Purpose: burst wrap and drive select register pair behind a serial port
// Assumes: clk far faster than sclk; spi mode 0, single data line
// Notes: array data come from outside; this block steers the addresses
`include "bwc_map.vh"

module bwc_top #(
	parameter ADDR_W = 24,
	parameter SYNC_W = 4
) (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire cs_n,
	input wire sclk,
	input wire si,
	input wire hw_reset_n,
	input wire [7:0] arr_data,
	output reg so,
	output reg so_oe,
	output reg arr_req,
	output reg [ADDR_W-1:0] arr_addr,
	output reg wrap_active,
	output reg wrap_en_n,
	output reg [1:0] wrap_len,
	output reg [2:0] drive_select_live,
	output reg [2:0] drive_strength
);

	// ============================================================
	// states
	localparam [2:0] ST_CMD = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_WDATA = 3'h2;
	localparam [2:0] ST_RDOUT = 3'h3;
	localparam [2:0] ST_ARRAY = 3'h4;
	localparam [2:0] ST_BURST = 3'h5;
	localparam [2:0] ST_SKIP = 3'h6;

	// ============================================================
	// pin synchronisers: cs_n, sclk, si, hw_reset_n
	wire [SYNC_W-1:0] pin_raw;
	reg [SYNC_W-1:0] sync1_reg;
	reg [SYNC_W-1:0] sync2_reg;
	reg sclk_prev_reg;
	// reset levels match the idle pins: cs_n, si and reset high, sclk low
	localparam [3:0] PIN_IDLE = 4'hd;

	assign pin_raw = {hw_reset_n, si, sclk, cs_n};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
			// idle levels at reset, so no false sclk edge follows it
			always @(posedge clk) begin
				if (!rstn) begin
					sync1_reg[gi] <= PIN_IDLE[gi];
					sync2_reg[gi] <= PIN_IDLE[gi];
				end else if (ce) begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	wire cs_n_s = sync2_reg[0];
	wire sclk_s = sync2_reg[1];
	wire si_s = sync2_reg[2];
	wire hwr_n_s = sync2_reg[3];
	wire sclk_rise = sclk_s & ~sclk_prev_reg;
	wire sclk_fall = ~sclk_s & sclk_prev_reg;

	// ============================================================
	// state and datapath registers
	reg [2:0] state_reg;
	reg [2:0] bit_cnt_reg;
	reg [6:0] in_sh_reg;
	reg [7:0] cmd_reg;
	reg [1:0] addr_cnt_reg;
	reg [ADDR_W-1:0] addr_reg;
	reg [7:0] live_reg;
	reg [7:0] out_sh_reg;
	reg load_pend_reg;
	reg rst_armed_reg;
	reg wrap_read_reg;
	reg boot_we_reg;
	reg [7:0] boot_wd_reg;
	wire [7:0] boot_q;

	wire [7:0] byte_in = {in_sh_reg, si_s};
	wire byte_done = sclk_rise & (bit_cnt_reg == 3'h7);
	wire [5:0] win_mask;

	// window mask for 8, 16, 32 or 64 byte bursts
	function [5:0] wrap_len_mask;
		input [1:0] code;
		begin
			wrap_len_mask = `BWC_WIN_MIN;
			case (code)
				2'h1: wrap_len_mask = 6'h0f;
				2'h2: wrap_len_mask = 6'h1f;
				2'h3: wrap_len_mask = 6'h3f;
				default: wrap_len_mask = `BWC_WIN_MIN;
			endcase
		end
	endfunction

	assign win_mask = wrap_len_mask(live_reg[`BWC_WLEN_HI:`BWC_WLEN_LO]);

	// next array address; low bits roll within the aligned window
	function [ADDR_W-1:0] next_addr;
		input [ADDR_W-1:0] a;
		input wrap;
		input [5:0] m;
		reg [ADDR_W-1:0] inc;
		reg [ADDR_W-1:0] wm;
		begin
			inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
			wm = {{(ADDR_W-6){1'b0}}, m};
			if (wrap)
				next_addr = (a & ~wm) | (inc & wm);
			else
				next_addr = inc;
		end
	endfunction

	// register read value; unmapped addresses read as zero
	reg [7:0] reg_rd;
	always @* begin
		reg_rd = 8'h00;
		if (addr_reg == `BWC_ADDR_BOOT)
			reg_rd = boot_q & `BWC_WRITE_MASK;
		else if (addr_reg == `BWC_ADDR_LIVE)
			reg_rd = live_reg & `BWC_WRITE_MASK;
	end

	// ============================================================
	// command sequencer
	always @(posedge clk) begin
		if (!rstn) begin
			sclk_prev_reg <= 1'b0;
			state_reg <= ST_CMD;
			bit_cnt_reg <= 3'h0;
			in_sh_reg <= 7'h00;
			cmd_reg <= 8'h00;
			addr_cnt_reg <= 2'h0;
			addr_reg <= {ADDR_W{1'b0}};
			live_reg <= `BWC_BOOT_DEFAULT;
			out_sh_reg <= 8'h00;
			load_pend_reg <= 1'b0;
			rst_armed_reg <= 1'b0;
			wrap_read_reg <= 1'b0;
			boot_we_reg <= 1'b0;
			boot_wd_reg <= 8'h00;
			so <= 1'b0;
			so_oe <= 1'b0;
			arr_req <= 1'b0;
			arr_addr <= {ADDR_W{1'b0}};
		end else if (ce) begin
			sclk_prev_reg <= sclk_s;
			boot_we_reg <= 1'b0;
			arr_req <= 1'b0;
			if (!hwr_n_s) begin
				// hardware reset pin: reload the working byte from boot
				live_reg <= boot_q;
				state_reg <= ST_CMD;
				bit_cnt_reg <= 3'h0;
				so_oe <= 1'b0;
				load_pend_reg <= 1'b0;
				rst_armed_reg <= 1'b0;
			end else if (cs_n_s) begin
				// deselect ends any command and releases the output
				state_reg <= ST_CMD;
				bit_cnt_reg <= 3'h0;
				so_oe <= 1'b0;
				load_pend_reg <= 1'b0;
			end else begin
				if (sclk_rise) begin
					bit_cnt_reg <= bit_cnt_reg + 3'h1;
					in_sh_reg <= byte_in[6:0];
				end
				if (byte_done) begin
					case (state_reg)
						ST_CMD: begin
							cmd_reg <= byte_in;
							addr_cnt_reg <= 2'h0;
							rst_armed_reg <= (byte_in == `BWC_CMD_RST_ENABLE);
							case (byte_in)
								`BWC_CMD_RD_ANY, `BWC_CMD_WR_ANY,
								`BWC_CMD_RD_SLOW, `BWC_CMD_RD_FAST,
								`BWC_CMD_RD_QUAD_IO, `BWC_CMD_RD_DDR_QUAD_IO:
									state_reg <= ST_ADDR;
								`BWC_CMD_SET_BURST:
									state_reg <= ST_BURST;
								`BWC_CMD_RST: begin
									if (rst_armed_reg)
										live_reg <= boot_q;
									state_reg <= ST_SKIP;
								end
								default:
									state_reg <= ST_SKIP;
							endcase
							// only the two quad io reads may wrap
							wrap_read_reg <= ~live_reg[`BWC_WRAP_EN_N] &
								((byte_in == `BWC_CMD_RD_QUAD_IO) |
								(byte_in == `BWC_CMD_RD_DDR_QUAD_IO));
						end
						ST_ADDR: begin
							addr_reg <= {addr_reg[ADDR_W-9:0], byte_in};
							addr_cnt_reg <= addr_cnt_reg + 2'h1;
							if (addr_cnt_reg == `BWC_ADDR_BYTES - 2'h1) begin
								if (cmd_reg == `BWC_CMD_WR_ANY) begin
									state_reg <= ST_WDATA;
								end else if (cmd_reg == `BWC_CMD_RD_ANY) begin
									// register read: wrap never applies
									state_reg <= ST_RDOUT;
									load_pend_reg <= 1'b1;
								end else begin
									state_reg <= ST_ARRAY;
									load_pend_reg <= 1'b1;
									arr_req <= 1'b1;
									arr_addr <= {addr_reg[ADDR_W-9:0], byte_in};
								end
							end
						end
						ST_WDATA: begin
							// reserved positions keep their zero default
							if (addr_reg == `BWC_ADDR_LIVE)
								live_reg <= byte_in & `BWC_WRITE_MASK;
							if (addr_reg == `BWC_ADDR_BOOT) begin
								boot_we_reg <= 1'b1;
								boot_wd_reg <= byte_in & `BWC_WRITE_MASK;
							end
							state_reg <= ST_SKIP;
						end
						ST_BURST: begin
							live_reg <= byte_in & `BWC_WRITE_MASK;
							state_reg <= ST_SKIP;
						end
						ST_RDOUT:
							load_pend_reg <= 1'b1;
						ST_ARRAY: begin
							// wrap mode was frozen at the command byte
							load_pend_reg <= 1'b1;
							arr_req <= 1'b1;
							arr_addr <= next_addr(arr_addr, wrap_read_reg,
								win_mask);
						end
						default:
							state_reg <= ST_SKIP;
					endcase
				end
				// data leave on the falling edge, msb first
				if (sclk_fall && (state_reg == ST_RDOUT ||
					state_reg == ST_ARRAY)) begin
					so_oe <= 1'b1;
					if (load_pend_reg) begin
						load_pend_reg <= 1'b0;
						if (state_reg == ST_RDOUT) begin
							so <= reg_rd[7];
							out_sh_reg <= {reg_rd[6:0], 1'b0};
						end else begin
							so <= arr_data[7];
							out_sh_reg <= {arr_data[6:0], 1'b0};
						end
					end else begin
						so <= out_sh_reg[7];
						out_sh_reg <= {out_sh_reg[6:0], 1'b0};
					end
				end
			end
		end
	end

	// ============================================================
	// controls in force, taken from the live byte; wrap_active from the wrap mode frozen at the command byte
	always @(posedge clk) begin
		if (!rstn) begin
			wrap_active <= 1'b0;
			wrap_en_n <= 1'b1;
			wrap_len <= 2'h0;
			drive_select_live <= 3'h0;
			drive_strength <= `BWC_DRIVE_NOMINAL;
		end else if (ce) begin
			wrap_active <= wrap_read_reg & (state_reg == ST_ARRAY);
			wrap_en_n <= live_reg[`BWC_WRAP_EN_N];
			wrap_len <= live_reg[`BWC_WLEN_HI:`BWC_WLEN_LO];
			drive_select_live <= live_reg[`BWC_DRIVE_HI:`BWC_DRIVE_LO];
			// factory code and code 3 give the same nominal strength
			if (live_reg[`BWC_DRIVE_HI:`BWC_DRIVE_LO] == `BWC_DRIVE_DUP)
				drive_strength <= `BWC_DRIVE_NOMINAL;
			else
				drive_strength <= live_reg[`BWC_DRIVE_HI:`BWC_DRIVE_LO];
		end
	end

	// ============================================================
	// boot byte storage
	bwc_bootstore #(
		.WIDTH(8),
		.INIT(`BWC_BOOT_DEFAULT)
	) u_boot (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.wr_en(boot_we_reg),
		.wr_data(boot_wd_reg),
		.rd_data(boot_q)
	);

endmodule

// file: verif/bwc_checker.sv
// Purpose: port checks of the burst wrap register pair
// Assumes: one clock domain, synchronous reset rstn
// Notes: array steps are tracked per frame
// ==========
// port checker
module bwc_checker #(
	parameter ADDR_W = 24
) (
	input wire clk,
	input wire rstn,
	input wire cs_n,
	input wire sclk,
	input wire hw_reset_n,
	input wire so,
	input wire so_oe,
	input wire arr_req,
	input wire [ADDR_W-1:0] arr_addr,
	input wire wrap_active,
	input wire wrap_en_n,
	input wire [1:0] wrap_len,
	input wire [2:0] drive_select_live,
	input wire [2:0] drive_strength
);
	reg [ADDR_W-1:0] last_addr;
	reg seen_req;
	wire [ADDR_W-1:0] win_mask;
	// window mask from the live length code
	assign win_mask = ~({ADDR_W{1'b1}} << ({1'b0, wrap_len} + 3'd3));
	// previous array step; cleared between frames
	always @(posedge clk) begin
		if (!rstn || cs_n) begin
			seen_req <= 1'b0;
		end else if (arr_req) begin
			seen_req <= 1'b1;
		end
		if (arr_req) begin
			last_addr <= arr_addr;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	drive_map_a: assert property ($stable(drive_select_live) |->
		drive_strength == (drive_select_live == 3'h0 ? 3'h3 :
		drive_select_live)) else $error("drive code wrong");
	oe_idle_a: assert property (cs_n [*6] |-> !so_oe)
		else $error("so driven while deselected");
	req_once_a: assert property (arr_req |=> !arr_req)
		else $error("array request too long");
	wrap_src_a: assert property ($rose(wrap_active) |-> !wrap_en_n)
		else $error("wrap while disabled");
	seq_step_a: assert property (arr_req && seen_req && !wrap_active
		|-> arr_addr == last_addr + 1'b1) else $error("bad step");
	wrap_step_a: assert property (arr_req && seen_req && wrap_active
		|-> arr_addr == (((last_addr + 1'b1) & win_mask) |
		(last_addr & ~win_mask))) else $error("bad wrap step");
	live_hold_a: assert property ((cs_n && hw_reset_n) [*8] |=>
		$stable({wrap_en_n, wrap_len, drive_select_live}))
		else $error("live byte moved while idle");
	so_edge_a: assert property (so_oe && $past(so_oe) && so != $past(so)
		|-> !$past(sclk, 2) && $past(sclk, 6)) else $error("so moved");
	cover property ($rose(wrap_active));
	cover property (arr_req && wrap_active && wrap_len == 2'h3);
	cover property ($fell(so_oe));
endmodule

bind bwc_top bwc_checker #(.ADDR_W(ADDR_W)) chk (
	.clk(clk),
	.rstn(rstn),
	.cs_n(cs_n),
	.sclk(sclk),
	.hw_reset_n(hw_reset_n),
	.so(so),
	.so_oe(so_oe),
	.arr_req(arr_req),
	.arr_addr(arr_addr),
	.wrap_active(wrap_active),
	.wrap_en_n(wrap_en_n),
	.wrap_len(wrap_len),
	.drive_select_live(drive_select_live),
	.drive_strength(drive_strength)
);

// file: verif/bwc_host.sv
// Purpose: serial host model, mode 0, msb first
// Assumes: sclk high and low 4 clk each, 64 ns period
// Notes: si flips on release so stale data never looks valid
// ==========
// host model
module bwc_host (
	input wire logic clk,
	input wire logic so,
	output logic cs_n,
	output logic sclk,
	output logic si
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle pins; sclk stands still outside frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end
	task sel;
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// deselect gap kept well above the 4 clk minimum
	task desel;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		si <= ~si;
		repeat (8) @(posedge clk);
	endtask
	// so taken late in the high phase, where it has long settled
	task xb(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si <= tx[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			rx = {rx[6:0], so};
			sclk <= 1'b0;
		end
	endtask
endmodule

// file: verif/tb_top.sv
// Purpose: self-checking bench of the burst wrap register pair
// Assumes: boot at 000004h, live at 800004h
// Notes: array byte is its address low byte xor a5h
// ==========
// bench
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hw_reset_n = 1'b1;
	logic [7:0] arr_data = 8'h00;
	wire cs_n, sclk, si, so, so_oe, arr_req, wrap_active, wrap_en_n;
	wire [23:0] arr_addr;
	wire [1:0] wrap_len;
	wire [2:0] drive_select_live, drive_strength;
	int err_total = 0;
	int n_checks = 0;
	always #4 clk = ~clk;
	// array answers one clk after the request, well inside its window
	always @(posedge clk) arr_data <= arr_addr[7:0] ^ 8'ha5;
	wire so_line;
	// a released line shows the inverse, so stale data never look valid
	assign so_line = so_oe ? so : ~so;
	bwc_top dut (
		.clk(clk),
		.rstn(rstn),
		.ce(1'b1),
		.cs_n(cs_n),
		.sclk(sclk),
		.si(si),
		.hw_reset_n(hw_reset_n),
		.arr_data(arr_data),
		.so(so),
		.so_oe(so_oe),
		.arr_req(arr_req),
		.arr_addr(arr_addr),
		.wrap_active(wrap_active),
		.wrap_en_n(wrap_en_n),
		.wrap_len(wrap_len),
		.drive_select_live(drive_select_live),
		.drive_strength(drive_strength)
	);
	bwc_host host (
		.clk(clk),
		.so(so_line),
		.cs_n(cs_n),
		.sclk(sclk),
		.si(si)
	);
	task ck(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task test_done;
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task hd(input logic [7:0] c, input logic [23:0] a, input bit na);
		logic [7:0] r;
		host.sel;
		host.xb(c, r);
		if (na)
			for (int k = 2; k >= 0; k--) host.xb(a[8*k +: 8], r);
	endtask
	task rr(input logic [23:0] a, output logic [7:0] r);
		hd(8'h65, a, 1'b1);
		host.xb(8'h00, r);
		host.desel;
	endtask
	task wr(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d);
		logic [7:0] r;
		hd(c, a, c == 8'h71);
		host.xb(d, r);
		host.desel;
	endtask
	// array read of six bytes; w of 0 means sequential
	task ar(input logic [7:0] c, input logic [7:0] a, input int w);
		logic [7:0] r, e;
		hd(c, {16'h0001, a}, 1'b1);
		for (int i = 0; i < 6; i++) begin
			host.xb(8'h00, r);
			e = 8'(w == 0 ? a + i :
				(a & ~(w - 1)) | ((a + i) & (w - 1)));
			ck(r, e ^ 8'ha5);
		end
		host.desel;
	endtask
	task t_reset_vals;
		logic [7:0] r;
		rr(24'h000004, r);
		ck(r, 8'h10);
		rr(24'h800004, r);
		ck(r, 8'h10);
		ck({drive_strength, wrap_en_n, 2'h0, wrap_len}, 8'h70);
	endtask
	task t_live_rw;
		logic [7:0] r;
		wr(8'h71, 24'h800004, 8'hff);
		rr(24'h800004, r);
		ck(r, 8'hf3);
		ck({drive_strength, wrap_en_n, 2'h0, wrap_len}, 8'hf3);
		ck({5'h0, drive_select_live}, 8'h07);
		wr(8'h71, 24'h800004, 8'h00);
		ck({drive_strength, wrap_en_n, 2'h0, wrap_len}, 8'h60);
		ck({5'h0, drive_select_live}, 8'h00);
		wr(8'h71, 24'h000005, 8'hff);
		rr(24'h000005, r);
		ck(r, 8'h00);
		rr(24'h000004, r);
		ck(r, 8'h10);
	endtask
	task t_wrap;
		logic [7:0] r;
		for (int c = 0; c < 4; c++) begin
			wr(8'hc0, 24'h0, c[7:0]);
			ck({6'h0, wrap_len}, c[7:0]);
			ar(c[0] ? 8'hed : 8'heb, 8'h3d, 8 << c);
		end
		rr(24'h000004, r);
		ck(r, 8'h10);
		rr(24'h800004, r);
		ck(r, 8'h03);
		ar(8'h03, 8'h3d, 0);
		ar(8'h0b, 8'h3d, 0);
		wr(8'hc0, 24'h0, 8'h10);
		ar(8'heb, 8'h3d, 0);
	endtask
	task t_resets;
		logic [7:0] r;
		wr(8'h71, 24'h000004, 8'h6d);
		rr(24'h000004, r);
		ck(r, 8'h61);
		hw_reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		hw_reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		rr(24'h800004, r);
		ck(r, 8'h61);
		ck({drive_strength, wrap_en_n, 2'h0, wrap_len}, 8'h61);
		wr(8'hc0, 24'h0, 8'hf3);
		hd(8'h66, 24'h0, 1'b0);
		host.desel;
		hd(8'h99, 24'h0, 1'b0);
		host.desel;
		rr(24'h800004, r);
		ck(r, 8'h61);
		// an unrelated command between the pair cancels the reset
		wr(8'hc0, 24'h0, 8'hf3);
		hd(8'h66, 24'h0, 1'b0);
		host.desel;
		hd(8'h05, 24'h0, 1'b0);
		host.desel;
		hd(8'h99, 24'h0, 1'b0);
		host.desel;
		rr(24'h800004, r);
		ck(r, 8'hf3);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rr(24'h000004, r);
		ck(r, 8'h10);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset_vals;
		t_live_rw;
		t_wrap;
		t_resets;
		test_done;
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		test_done;
	end
endmodule
